// File: rtl/dei_interlock.sv
// drive enable gating, alarm lock and reset interlock
// assumes one clock; terminal and link bits arrive unsynchronised
`include "dei_defines.svh"
`default_nettype none

// Function
// - drive needs both safety enables active
// - active remote boards need enable unless local-only
// - enable fixed to safety terminals, shareable
// - inactive enable forces output off, coasting
// - hardware drop shuts output after fixed delay
// - software timer delays only rising enable
// - scalar control: run below threshold disables
// - pid regulator may force disable
// - remote enable drop disables instantly
// - alarm disables, coasts, locks, indicates
// - enable arms configuration consistency checks
// - enable write-locks config unless standby edit
// - vector/field control fluxes with run, setting
// - safety start refuses enable present at power-on
// - reset terminal clears alarms unless disabled
// - reset clears lock only if cause gone
// - safety start: enable off-on restarts drive
// - stored alarms relock drive at power-up
// - reset removed: one other terminal function
// - reset disable bit0, local-only bit1
// - multi assignment: two functions per terminal
module dei_interlock #(
   parameter int unsigned SHUT_CYC = `DEI_SHUT_DELAY_NS / `DEI_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // register port
   input wire logic [`DEI_ADDR_W-1:0] regAddr,
   input wire logic [`DEI_DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [`DEI_DATA_W-1:0] regRdata,
   // terminals, links and drive state
   input wire dei_pkg::dei_pins_type pins,
   input wire logic storedAlarm,
   // drive control outputs
   output var dei_pkg::dei_out_type drv
);
   if (SHUT_CYC < 1 || SHUT_CYC > 65535) begin : g_chk
      $error("SHUT_CYC out of range");
   end

   localparam logic [15:0] SHUT_LAST = 16'(SHUT_CYC - 1);

   dei_pkg::dei_state_type st_r;
   dei_pkg::dei_state_type st_nxt;

   logic remoteOk;
   logic hwOk;
   logic gate;
   logic rstPulse;
   logic locked;
   logic pidDis;
   logic thrDis;
   logic [1:0] fnLimit;

   function automatic logic isEnabled(input dei_pkg::dei_fsm_type f);
      isEnabled = (f == dei_pkg::DEI_ON) || (f == dei_pkg::DEI_SHUT);
   endfunction

   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   always_comb begin
      st_nxt = st_r;
      // first stage feeds only the second stage
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.rstPrev = st_r.s2.resetTerm;
      st_nxt.keyPrev = st_r.s2.keypadReset;

      // series connection of the two safety inputs
      hwOk = st_r.s2.enableA & st_r.s2.enableB;
      // inactive boards are not asked
      remoteOk = st_r.cfg.localOnly |
                 ((~st_r.cfg.serActive | st_r.s2.serialEnable) &
                  (~st_r.cfg.fbActive | st_r.s2.fieldbusEnable));
      gate = hwOk & remoteOk;

      rstPulse = (rise(st_r.s2.resetTerm, st_r.rstPrev) & ~st_r.cfg.rstInDis) |
                 rise(st_r.s2.keypadReset, st_r.keyPrev);

      locked = isEnabled(st_r.fsm) &
               ~(st_r.cfg.editStbyFlux & ~st_r.s2.motorRunning);

      pidDis = st_r.cfg.pidDisEn & st_r.s2.pidReq;
      thrDis = st_r.s2.runCmd & st_r.s2.refBelow &
               ((st_r.cfg.mode == dei_pkg::DEI_SCALAR) | st_r.cfg.thrOtherEn);

      // reset function occupies one slot unless removed
      fnLimit = (st_r.cfg.rstInDis | st_r.cfg.multiAssign) ?
                `DEI_FNS_EXTRA_MAX : `DEI_FNS_NONE;

      // enable path
      case (st_r.fsm)
         dei_pkg::DEI_OFF: begin
            st_nxt.cnt = `DEI_CNT_ZERO;
            if (gate) begin
               st_nxt.fsm = (st_r.onDelay == `DEI_CNT_ZERO) ?
                            dei_pkg::DEI_ON : dei_pkg::DEI_ONDLY;
            end
         end
         dei_pkg::DEI_ONDLY: begin
            st_nxt.cnt = 16'(st_r.cnt + `DEI_CNT_ONE);
            if (!gate) begin
               st_nxt.fsm = dei_pkg::DEI_OFF;
            end else if (st_nxt.cnt >= st_r.onDelay) begin
               st_nxt.fsm = dei_pkg::DEI_ON;
            end
         end
         dei_pkg::DEI_ON: begin
            st_nxt.cnt = `DEI_CNT_ZERO;
            if (!remoteOk) begin
               st_nxt.fsm = dei_pkg::DEI_OFF;
            end else if (!hwOk) begin
               // timer on the terminal plays no part here
               st_nxt.fsm = st_r.out.driveEnable ?
                            dei_pkg::DEI_SHUT : dei_pkg::DEI_OFF;
            end
         end
         dei_pkg::DEI_SHUT: begin
            st_nxt.cnt = 16'(st_r.cnt + `DEI_CNT_ONE);
            // delay runs from the drop, a returning input does not stop it
            if (!remoteOk || st_r.cnt >= SHUT_LAST) begin
               st_nxt.fsm = dei_pkg::DEI_OFF;
            end
         end
         default: begin
            st_nxt.fsm = dei_pkg::DEI_OFF;
            st_nxt.cnt = `DEI_CNT_ZERO;
         end
      endcase

      // power-up capture once synchronisers have settled
      if (!st_r.initDone) begin
         st_nxt.settle = 2'(st_r.settle + `DEI_SETTLE_ONE);
         if (st_r.settle == `DEI_SETTLE_DONE) begin
            st_nxt.initDone = 1'b1;
            st_nxt.startBlock = st_r.cfg.safetyStart & gate;
            st_nxt.out.alarmLocked = st_r.out.alarmLocked | storedAlarm;
         end
      end else if (!gate) begin
         st_nxt.startBlock = 1'b0;
      end

      // alarm lock, a trip in the reset cycle wins
      if (rstPulse && !st_r.s2.protTrip) begin
         st_nxt.out.alarmLocked = 1'b0;
      end
      if (st_r.s2.protTrip) begin
         st_nxt.out.alarmLocked = 1'b1;
      end

      // registers
      if (regWrite && !locked) begin
         case (regAddr)
            `DEI_ADDR_CFG: st_nxt.cfg = dei_pkg::dei_cfg_type'(regWdata);
            `DEI_ADDR_TIMER: st_nxt.onDelay = regWdata;
            `DEI_ADDR_MAP: begin
               if (regWdata[1:0] <= fnLimit) begin
                  st_nxt.extraFns = regWdata[1:0];
                  st_nxt.mapRefused = 1'b0;
               end else begin
                  st_nxt.mapRefused = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      st_nxt.rdata = `DEI_RDATA_RST;
      if (regRead) begin
         case (regAddr)
            `DEI_ADDR_CFG: st_nxt.rdata = st_r.cfg;
            `DEI_ADDR_TIMER: st_nxt.rdata = st_r.onDelay;
            `DEI_ADDR_MAP: st_nxt.rdata = {14'h0000, st_r.extraFns};
            `DEI_ADDR_STATUS: st_nxt.rdata = {`DEI_STAT_PAD, st_r.mapRefused, st_r.startBlock,
                                            st_r.out.alarmLocked, locked, st_r.out.fluxOn,
                                            st_r.out.driveEnable, hwOk, remoteOk};
            default: st_nxt.rdata = `DEI_RDATA_RST;
         endcase
      end

      // outputs; drive, flux and check arm taken from next state so drops act at once, hwEnable and writeLocked from current state
      st_nxt.out.hwEnable = hwOk;
      st_nxt.out.cfgCheckArm = isEnabled(st_nxt.fsm);
      st_nxt.out.writeLocked = locked;
      st_nxt.out.fluxOn = isEnabled(st_nxt.fsm) & st_r.s2.runCmd & st_r.cfg.fluxNeedsRun &
                          ((st_r.cfg.mode == dei_pkg::DEI_VECTOR) |
                           (st_r.cfg.mode == dei_pkg::DEI_FIELD));
      st_nxt.out.driveEnable = isEnabled(st_nxt.fsm) & st_nxt.initDone &
                               ~st_nxt.out.alarmLocked & ~st_nxt.startBlock &
                               ~pidDis & ~thrDis;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.fsm <= dei_pkg::DEI_OFF;
         st_r.cfg <= dei_pkg::dei_cfg_type'(`DEI_CFG_RST);
         st_r.onDelay <= `DEI_TIMER_RST;
         st_r.extraFns <= `DEI_MAP_RST;
         st_r.settle <= `DEI_SETTLE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign drv = st_r.out;
   assign regRdata = st_r.rdata;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   property p_hw_follows;
      (st_r.s2.enableA & st_r.s2.enableB) |=> st_r.out.hwEnable;
   endproperty
   a_hw_follows: assert property (p_hw_follows) else $error("combined enable missed");

   property p_remote_drop;
      (isEnabled(st_r.fsm) && !remoteOk) |=> (st_r.fsm == dei_pkg::DEI_OFF) && !st_r.out.driveEnable;
   endproperty
   a_remote_drop: assert property (p_remote_drop) else $error("remote drop not instant");

   property p_shut_holds;
      (st_r.fsm == dei_pkg::DEI_SHUT && st_r.cnt == `DEI_CNT_ZERO && remoteOk)
         |-> (st_r.fsm == dei_pkg::DEI_SHUT)[*2];
   endproperty
   a_shut_holds: assert property (p_shut_holds) else $error("shut delay cut short");

   property p_timer_fall;
      (st_r.fsm == dei_pkg::DEI_ONDLY && !gate) |=> st_r.fsm == dei_pkg::DEI_OFF;
   endproperty
   a_timer_fall: assert property (p_timer_fall) else $error("disable edge delayed");

   property p_timer_rise;
      (st_r.fsm == dei_pkg::DEI_OFF && gate && st_r.onDelay != `DEI_CNT_ZERO)
         |=> st_r.fsm == dei_pkg::DEI_ONDLY;
   endproperty
   a_timer_rise: assert property (p_timer_rise) else $error("enable edge not delayed");

   property p_alarm_blocks;
      st_r.s2.protTrip |=> st_r.out.alarmLocked && !st_r.out.driveEnable;
   endproperty
   a_alarm_blocks: assert property (p_alarm_blocks) else $error("trip did not lock");

   property p_cause_keeps;
      (rstPulse && st_r.s2.protTrip) |=> st_r.out.alarmLocked;
   endproperty
   a_cause_keeps: assert property (p_cause_keeps) else $error("lock cleared with cause");

   property p_reset_disabled;
      (st_r.out.alarmLocked && st_r.cfg.rstInDis && !st_r.s2.protTrip &&
       !rise(st_r.s2.keypadReset, st_r.keyPrev)) |=> st_r.out.alarmLocked;
   endproperty
   a_reset_disabled: assert property (p_reset_disabled) else $error("disabled reset acted");

   property p_write_lock;
      (regWrite && locked && regAddr == `DEI_ADDR_CFG) |=> st_r.cfg == $past(st_r.cfg);
   endproperty
   a_write_lock: assert property (p_write_lock) else $error("locked config written");

   property p_flux;
      st_r.out.fluxOn |-> $past(st_r.cfg.fluxNeedsRun && st_r.s2.runCmd);
   endproperty
   a_flux: assert property (p_flux) else $error("flux without run");

   property p_map_limit;
      !(st_r.cfg.rstInDis | st_r.cfg.multiAssign) && regWrite && !locked &&
      regAddr == `DEI_ADDR_MAP && regWdata[1:0] != `DEI_FNS_NONE |=> st_r.mapRefused;
   endproperty
   a_map_limit: assert property (p_map_limit) else $error("terminal overbooked");

   property p_start_block;
      st_r.startBlock |-> !st_r.out.driveEnable;
   endproperty
   a_start_block: assert property (p_start_block) else $error("safety start ignored");

   property p_coast;
      !isEnabled(st_r.fsm) |-> !st_r.out.driveEnable;
   endproperty
   a_coast: assert property (p_coast) else $error("drive on while disabled");

   property p_timer_wait;
      (st_r.fsm == dei_pkg::DEI_ONDLY) |-> !st_r.out.driveEnable;
   endproperty
   a_timer_wait: assert property (p_timer_wait) else $error("drive on during enable delay");

   property p_thr_dis;
      (st_r.s2.runCmd && st_r.s2.refBelow && st_r.cfg.mode == dei_pkg::DEI_SCALAR)
         |=> !st_r.out.driveEnable;
   endproperty
   a_thr_dis: assert property (p_thr_dis) else $error("threshold disable missed");

   property p_pid_dis;
      (st_r.cfg.pidDisEn && st_r.s2.pidReq) |=> !st_r.out.driveEnable;
   endproperty
   a_pid_dis: assert property (p_pid_dis) else $error("pid disable missed");

   property p_arm_off;
      (st_r.fsm == dei_pkg::DEI_OFF) |-> !st_r.out.cfgCheckArm;
   endproperty
   a_arm_off: assert property (p_arm_off) else $error("checks armed while disabled");

   property p_timer_lock;
      (regWrite && locked && regAddr == `DEI_ADDR_TIMER) |=> st_r.onDelay == $past(st_r.onDelay);
   endproperty
   a_timer_lock: assert property (p_timer_lock) else $error("locked timer written");

   property p_flux_mode;
      st_r.out.fluxOn |-> $past(st_r.cfg.mode) != dei_pkg::DEI_SCALAR;
   endproperty
   a_flux_mode: assert property (p_flux_mode) else $error("flux in scalar control");

   property p_early_off;
      !st_r.initDone |-> !st_r.out.driveEnable;
   endproperty
   a_early_off: assert property (p_early_off) else $error("drive on before capture");

   property p_reset_clears;
      (rstPulse && !st_r.s2.protTrip) |=> !st_r.out.alarmLocked;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset pulse did not unlock");

   property p_power_lock;
      (!st_r.initDone && st_r.settle == `DEI_SETTLE_DONE && storedAlarm && !rstPulse)
         |=> st_r.out.alarmLocked;
   endproperty
   a_power_lock: assert property (p_power_lock) else $error("stored alarm not relocked");

   property p_sync_stage;
      st_r.s2 == $past(st_r.s1);
   endproperty
   a_sync_stage: assert property (p_sync_stage) else $error("synchroniser stage skipped");

   property p_drive_clean;
      st_r.out.driveEnable |-> !st_r.out.alarmLocked && !st_r.startBlock;
   endproperty
   a_drive_clean: assert property (p_drive_clean) else $error("drive on while locked");
endmodule

`default_nettype wire

// File: rtl/dei_defines.svh
// constants of the drive enable and reset interlock
// assumes one 50 MHz system clock and the plain register port
`ifndef DEI_DEFINES_SVH
`define DEI_DEFINES_SVH
`define DEI_ADDR_W 2
`define DEI_DATA_W 16
`define DEI_ADDR_CFG 2'h0
`define DEI_ADDR_TIMER 2'h1
`define DEI_ADDR_MAP 2'h2
`define DEI_ADDR_STATUS 2'h3
`define DEI_CFG_RST 16'h0000
`define DEI_TIMER_RST 16'h0000
`define DEI_CNT_ZERO 16'h0000
`define DEI_CNT_ONE 16'h0001
`define DEI_MAP_RST 2'h0
`define DEI_FNS_NONE 2'h0
`define DEI_FNS_EXTRA_MAX 2'h1
`define DEI_SETTLE_RST 2'h0
`define DEI_SETTLE_ONE 2'h1
`define DEI_SETTLE_DONE 2'h3
`define DEI_RDATA_RST 16'h0000
`define DEI_STAT_PAD 8'h00
`define DEI_CLK_PERIOD_NS 20
`define DEI_SHUT_DELAY_NS 2000
`endif

// File: rtl/dei_pkg.sv
// types of the drive enable and reset interlock
// assumes the defines header is compiled with it
`default_nettype none
package dei_pkg;
   typedef enum logic [3:0] {
      DEI_OFF = 4'b0001,
      DEI_ONDLY = 4'b0010,
      DEI_ON = 4'b0100,
      DEI_SHUT = 4'b1000
   } dei_fsm_type;

   typedef enum logic [1:0] {
      DEI_SCALAR = 2'h0,
      DEI_VECTOR = 2'h1,
      DEI_FIELD = 2'h2,
      DEI_MODE_RSVD = 2'h3
   } dei_mode_type;

   // bit 0 upward: rstInDis, localOnly, safetyStart, ...
   typedef struct packed {
      logic [3:0] spare;
      logic thrOtherEn;
      logic pidDisEn;
      dei_mode_type mode;
      logic fbActive;
      logic serActive;
      logic editStbyFlux;
      logic multiAssign;
      logic fluxNeedsRun;
      logic safetyStart;
      logic localOnly;
      logic rstInDis;
   } dei_cfg_type;

   typedef struct packed {
      logic enableA;
      logic enableB;
      logic resetTerm;
      logic serialEnable;
      logic fieldbusEnable;
      logic keypadReset;
      logic runCmd;
      logic refBelow;
      logic pidReq;
      logic protTrip;
      logic motorRunning;
   } dei_pins_type;

   typedef struct packed {
      logic driveEnable;
      logic hwEnable;
      logic fluxOn;
      logic cfgCheckArm;
      logic alarmLocked;
      logic writeLocked;
   } dei_out_type;

   typedef struct packed {
      dei_pins_type s1;
      dei_pins_type s2;
      logic rstPrev;
      logic keyPrev;
      logic [1:0] settle;
      logic initDone;
      dei_fsm_type fsm;
      logic [15:0] cnt;
      dei_cfg_type cfg;
      logic [15:0] onDelay;
      logic [1:0] extraFns;
      logic mapRefused;
      logic startBlock;
      dei_out_type out;
      logic [15:0] rdata;
   } dei_state_type;
endpackage
`default_nettype wire

// File: sim/dei_operator_model.sv
// operator terminal model: reset terminal and keypad reset key
// assumes one-cycle request strobes from the bench on the same clock
`default_nettype none
module dei_operator_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // requests
   input wire logic pulseTerm,
   input wire logic pulseKey,
   // operator outputs
   output logic resetTerm,
   output logic keypadReset
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] termCnt;
   logic [2:0] keyCnt;
   // held four cycles so the two-flop sync cannot miss it
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         termCnt <= 3'h0;
         keyCnt <= 3'h0;
      end else begin
         termCnt <= pulseTerm ? 3'h4 : (termCnt != 3'h0 ? termCnt - 3'h1 : 3'h0);
         keyCnt <= pulseKey ? 3'h4 : (keyCnt != 3'h0 ? keyCnt - 3'h1 : 3'h0);
      end
   end
   assign resetTerm = termCnt != 3'h0;
   assign keypadReset = keyCnt != 3'h0;
endmodule
`default_nettype wire

// File: sim/drive_enable_reset_interlock_bench.sv
// self-checking bench of the drive enable and reset interlock
// assumes rtl/ and the operator model are compiled first
`include "dei_defines.svh"
`default_nettype none
module drive_enable_reset_interlock_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdata;
   logic storedAlarm = 1'b0;
   logic pTerm = 1'b0;
   logic pKey = 1'b0;
   logic resetTerm;
   logic keypadReset;
   dei_pkg::dei_pins_type pb = '0;
   dei_pkg::dei_pins_type pins;
   dei_pkg::dei_out_type drv;
   int errCount = 0;
   int nChecks = 0;
   int cycCnt = 0;

   always #10 clock = ~clock;
   always_comb begin
      pins = pb;
      pins.resetTerm = resetTerm;
      pins.keypadReset = keypadReset;
   end

   dei_interlock #(.SHUT_CYC(2)) u_dei_interlock (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pins(pins),
      .storedAlarm(storedAlarm), .drv(drv));
   dei_operator_model u_dei_operator_model (.clock(clock), .rst_b(rst_b), .pulseTerm(pTerm),
      .pulseKey(pKey), .resetTerm(resetTerm), .keypadReset(keypadReset));

   task automatic finalReport();
      $display("checks %0d errors %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic setp(input dei_pkg::dei_pins_type v);
      @(posedge clock);
      pb <= v;
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic pulse(input logic key);
      @(posedge clock);
      pKey <= key;
      pTerm <= !key;
      @(posedge clock);
      pKey <= 1'b0;
      pTerm <= 1'b0;
      cyc(8);
   endtask
   // scalar mode is 0; threshold applies there or anywhere with bit 11
   function automatic logic expDe(input dei_pkg::dei_pins_type v, input logic [15:0] c);
      logic g;
      g = v.enableA & v.enableB & (c[1] | ((!c[6] | v.serialEnable) & (!c[7] | v.fieldbusEnable)));
      return g & !(v.pidReq & c[10]) & !(v.runCmd & v.refBelow & (c[9:8] == 2'h0 | c[11]));
   endfunction

   always @(posedge clock) begin
      cycCnt++;
      if (cycCnt > 5000) begin
         errCount++;
         finalReport();
      end
   end

   initial begin
      dei_pkg::dei_pins_type v;
      dei_pkg::dei_pins_type gd;
      logic [15:0] c;
      logic [15:0] d;
      logic [5:0] r;
      logic e;
      void'($urandom(96));
      gd = '0;
      gd.enableA = 1'b1;
      gd.enableB = 1'b1;
      gd.serialEnable = 1'b1;
      gd.fieldbusEnable = 1'b1;
      cyc(6);
      #1 check(16'(drv), 16'h0000);
      cyc(6);
      rst_b <= 1'b1;
      rd(`DEI_ADDR_CFG, d);
      check(d, `DEI_CFG_RST);
      for (int i = 0; i < 12; i++) begin
         setp('0);
         cyc(8);
         r = 6'($urandom);
         c = {4'h0, r[1:0], 2'($urandom_range(2)), r[3:2], 2'h0, r[4], 1'b0, r[5], 1'b0};
         wr(`DEI_ADDR_CFG, c);
         v = dei_pkg::dei_pins_type'(11'($urandom));
         v.protTrip = 1'b0;
         if (i < 4) begin
            v.enableA = 1'b1;
            v.enableB = 1'b1;
         end
         setp(v);
         cyc(8);
         e = expDe(v, c);
         #1 check(16'(drv.driveEnable), 16'(e));
         check(16'(drv.hwEnable), 16'(v.enableA & v.enableB));
         if (e) check(16'(drv.fluxOn), 16'(v.runCmd & c[3] & (c[9:8] != 2'h0)));
      end
      setp('0);
      cyc(8);
      wr(`DEI_ADDR_CFG, 16'h0060);
      wr(`DEI_ADDR_TIMER, 16'h0005);
      setp(gd);
      cyc(5);
      #1 check(16'(drv.driveEnable), 16'h0000);
      cyc(6);
      #1 check(16'(drv), 16'h0034);
      wr(`DEI_ADDR_CFG, 16'h1060);
      v = gd;
      v.motorRunning = 1'b1;
      setp(v);
      cyc(4);
      #1 check(16'(drv.writeLocked), 16'h0001);
      wr(`DEI_ADDR_CFG, 16'h0060);
      rd(`DEI_ADDR_CFG, d);
      check(d, 16'h1060);
      v.serialEnable = 1'b0;
      setp(v);
      cyc(3);
      #1 check(16'(drv.driveEnable), 16'h0000);
      v.serialEnable = 1'b1;
      setp(v);
      cyc(14);
      v.enableB = 1'b0;
      setp(v);
      cyc(3);
      #1 check(16'(drv.driveEnable), 16'h0001);
      cyc(4);
      #1 check(16'(drv), 16'h0000);
      wr(`DEI_ADDR_TIMER, 16'h0000);
      v = gd;
      setp(v);
      cyc(6);
      v.protTrip = 1'b1;
      setp(v);
      cyc(4);
      #1 check(16'({drv.driveEnable, drv.alarmLocked}), 16'h0001);
      pulse(1'b0);
      #1 check(16'(drv.alarmLocked), 16'h0001);
      v.protTrip = 1'b0;
      setp(v);
      cyc(4);
      pulse(1'b0);
      #1 check(16'({drv.driveEnable, drv.alarmLocked}), 16'h0002);
      setp('0);
      cyc(8);
      wr(`DEI_ADDR_CFG, 16'h0001);
      for (int k = 0; k < 3; k++) begin
         v.protTrip = (k == 1);
         setp(v);
         cyc(5);
      end
      pulse(1'b0);
      #1 check(16'(drv.alarmLocked), 16'h0001);
      pulse(1'b1);
      #1 check(16'(drv.alarmLocked), 16'h0000);
      setp('0);
      cyc(8);
      wr(`DEI_ADDR_MAP, 16'h0002);
      rd(`DEI_ADDR_STATUS, d);
      check(d & 16'h0080, 16'h0080);
      @(posedge clock);
      #1 check(regRdata, `DEI_RDATA_RST);
      wr(`DEI_ADDR_MAP, 16'h0001);
      rd(`DEI_ADDR_MAP, d);
      check(d, 16'h0001);
      // reset function kept and no multi assignment: no extra slot
      wr(`DEI_ADDR_CFG, 16'h0000);
      wr(`DEI_ADDR_MAP, 16'h0001);
      rd(`DEI_ADDR_STATUS, d);
      check(d & 16'h0080, 16'h0080);
      wr(`DEI_ADDR_CFG, 16'h0010);
      wr(`DEI_ADDR_MAP, 16'h0001);
      rd(`DEI_ADDR_STATUS, d);
      check(d & 16'h0080, 16'h0000);
      @(posedge clock);
      pb <= gd;
      storedAlarm <= 1'b1;
      rst_b <= 1'b0;
      cyc(3);
      rst_b <= 1'b1;
      // safety start must land before the power-up capture
      wr(`DEI_ADDR_CFG, 16'h0004);
      cyc(6);
      #1 check(16'(drv.alarmLocked), 16'h0001);
      pulse(1'b1);
      #1 check(16'(drv.alarmLocked), 16'h0000);
      check(16'(drv.driveEnable), 16'h0000);
      rd(`DEI_ADDR_STATUS, d);
      check(d & 16'h0040, 16'h0040);
      v = gd;
      v.enableA = 1'b0;
      setp(v);
      cyc(5);
      #1 check(16'(drv.driveEnable), 16'h0000);
      setp(gd);
      cyc(5);
      #1 check(16'(drv.driveEnable), 16'h0001);
      finalReport();
   end
endmodule
`default_nettype wire
